// [design/disk_panel_interlock_logic.sv]
// Front-panel sequencing, interlock and lamp logic for a cartridge drive.
`timescale 1ns/100ps
`include "panel_defines.svh"

////////////////////////////////////////////////////////////////////////////
// What this block does
// - Run with safe interlocks: lock, spin, load, lamp.
// - Park: unload heads, stop, unlock, park lamp.
// - Park removes motor power; spindle coasts.
// - First lock press sets lock, clears fault.
// - Second press clears lock; presses toggle.
// - Host write-protect command sets write lock.
// - Park-then-run cycle clears write lock.
// - Ready only at speed, loaded, interlocks safe.
// - On-track only when ready, idle, settled.
// - Fault on stray write current or lamp failure.
// - Fault holds until lock press or recycle.
// - Park lamp once retracted and stopped.
// - Write lamp follows each write operation.
// - Read lamp follows each read operation.
// - Revolution interval of 45 ms or more cycles down.
// - Missing cartridge is an unsafe interlock.
module disk_panel_interlock_logic
  import panel_pkg::*;
#(
  parameter int unsigned REV_LIMIT_CYC = `PANEL_REV_LIMIT_CYC,
  parameter int unsigned DEBOUNCE_CYC  = `PANEL_DEBOUNCE_CYC,
  parameter int unsigned SPIN_TMO_CYC  = `PANEL_SPIN_TMO_CYC
) (
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Operator switches.
  input  wire logic        run_select_i,
  input  wire logic        write_lock_sw_i,
  // Sensors from the drive mechanics.
  input  wire logic        cartridge_seated_i,
  input  wire logic        door_closed_i,
  input  wire logic        speed_ok_i,
  input  wire logic        heads_loaded_i,
  input  wire logic        heads_retracted_i,
  input  wire logic        spindle_stopped_i,
  input  wire logic        index_pulse_i,
  input  wire logic        transducer_lamp_ok_i,
  input  wire logic        erase_current_i,
  input  wire logic        write_current_i,
  // Drive controller status.
  input  wire logic        write_gate_i,
  input  wire logic        read_gate_i,
  input  wire logic        seek_busy_i,
  input  wire logic        heads_settled_i,
  input  wire logic        power_good_i,
  // Electromechanical drives.
  output logic             door_lock_o,
  output logic             motor_power_o,
  output logic             head_load_o,
  output logic             write_inhibit_o,
  // Panel lamps.
  output logic             run_lamp_o,
  output logic             park_lamp_o,
  output logic             ready_lamp_o,
  output logic             settled_position_lamp_o,
  output logic             fault_lamp_o,
  output logic             write_lock_lamp_o,
  output logic             write_activity_lamp_o,
  output logic             read_activity_lamp_o,
  output logic             power_lamp_o,
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning.

  switch_if lock_sw ();
  switch_if run_sw ();

  // The lock switch is momentary; its debounced press drives the toggle.
  switch_debounce #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_lock_db (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .raw_i     (write_lock_sw_i),
    .sw        (lock_sw)
  );

  // The selector is debounced too, so contact chatter cannot recycle.
  switch_debounce #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_run_db (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .raw_i     (run_select_i),
    .sw        (run_sw)
  );

  // Mechanical sensors cross in through three flip-flops each.
  localparam int unsigned N_SENSE = 14;
  logic [N_SENSE-1:0] sense_raw;
  logic [N_SENSE-1:0] s1_r;
  logic [N_SENSE-1:0] s2_r;
  logic [N_SENSE-1:0] s3_r;
  logic [N_SENSE-1:0] sense_r;
  logic [N_SENSE-1:0] sense_nxt;

  assign sense_raw = {cartridge_seated_i, door_closed_i, speed_ok_i,
                      heads_loaded_i, heads_retracted_i, spindle_stopped_i,
                      index_pulse_i, transducer_lamp_ok_i, erase_current_i,
                      write_current_i, write_gate_i, read_gate_i,
                      seek_busy_i, heads_settled_i};

  // A sensor counts as changed once stages two and three agree.
  genvar gi;
  generate
    for (gi = 0; gi < N_SENSE; gi++) begin : g_sense
      always_comb begin
        sense_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : sense_r[gi];
      end
    end
  endgenerate

  // Register the synchroniser stages; a good lamp must not look failed.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s1_r    <= `PANEL_SENSE_RST;
      s2_r    <= `PANEL_SENSE_RST;
      s3_r    <= `PANEL_SENSE_RST;
      sense_r <= `PANEL_SENSE_RST;
    end else begin
      s1_r    <= sense_raw;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      sense_r <= sense_nxt;
    end
  end

  logic cart_ok, door_ok, at_speed, hd_loaded, hd_retr, spin_stop;
  logic index_lv, lamp_ok, erase_cur, write_cur, wgate, rgate;
  logic seek_busy, settled;
  assign {cart_ok, door_ok, at_speed, hd_loaded, hd_retr, spin_stop,
          index_lv, lamp_ok, erase_cur, write_cur, wgate, rgate,
          seek_busy, settled} = sense_r;

  ////////////////////////////////////////////////////////////////////////////
  // Revolution interval monitor.

  logic [31:0] rev_cnt_r;
  logic [31:0] rev_cnt_nxt;
  logic        index_d_r;
  logic        overspeed_trip;

  // The counter restarts on each index edge; it stops counting at REV_LIMIT_CYC.
  always_comb begin
    rev_cnt_nxt = rev_cnt_r;
    if (index_lv && !index_d_r) begin
      rev_cnt_nxt = 32'h0;
    end else if (rev_cnt_r < REV_LIMIT_CYC) begin
      rev_cnt_nxt = rev_cnt_r + 32'h1;
    end
  end

  // Register the interval counter.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rev_cnt_r <= 32'h0;
      index_d_r <= 1'b0;
    end else begin
      rev_cnt_r <= rev_cnt_nxt;
      index_d_r <= index_lv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive sequencer.

  drive_state_type state_r;
  drive_state_type state_nxt;
  logic [31:0]     tmo_r;
  logic [31:0]     tmo_nxt;
  logic            interlock_safe;
  logic            recycle;
  logic            was_parked_r;
  logic            was_parked_nxt;

  // A missing cartridge or open door forbids running.
  assign interlock_safe = cart_ok && door_ok && lamp_ok;

  // Trips only once the spindle should be at speed.
  assign overspeed_trip = (state_r == ST_RUNNING) &&
                          (rev_cnt_r >= REV_LIMIT_CYC);

  // Next state; a lost interlock or slow spindle cycles the drive down.
  always_comb begin
    state_nxt      = state_r;
    tmo_nxt        = (tmo_r < SPIN_TMO_CYC) ? tmo_r + 32'h1 : tmo_r;
    was_parked_nxt = was_parked_r;
    recycle        = 1'b0;
    case (state_r)
      ST_PARKED: begin
        tmo_nxt = 32'h0;
        if (spin_stop && hd_retr) begin
          was_parked_nxt = 1'b1;
        end
        if (run_sw.level && interlock_safe) begin
          state_nxt      = ST_SPINUP;
          recycle        = was_parked_r;
          was_parked_nxt = 1'b0;
        end
      end
      ST_SPINUP: begin
        if (!run_sw.level || !interlock_safe || tmo_r >= SPIN_TMO_CYC) begin
          state_nxt = ST_SPINDOWN;
        end else if (at_speed) begin
          state_nxt = ST_LOADHD;
          tmo_nxt   = 32'h0;
        end
      end
      ST_LOADHD: begin
        if (!run_sw.level || !interlock_safe || tmo_r >= SPIN_TMO_CYC) begin
          state_nxt = ST_UNLOADHD;
        end else if (hd_loaded) begin
          state_nxt = ST_RUNNING;
        end
      end
      ST_RUNNING: begin
        tmo_nxt = 32'h0;
        if (!run_sw.level || !interlock_safe || overspeed_trip) begin
          state_nxt = ST_UNLOADHD;
        end
      end
      ST_UNLOADHD: begin
        if (hd_retr) begin
          state_nxt = ST_SPINDOWN;
        end
      end
      ST_SPINDOWN: begin
        if (spin_stop) begin
          state_nxt = ST_PARKED;
        end
      end
      default: begin
        state_nxt = ST_UNLOADHD;
      end
    endcase
  end

  // Register the sequencer.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_r      <= ST_UNLOADHD;
      tmo_r        <= 32'h0;
      was_parked_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      tmo_r        <= tmo_nxt;
      was_parked_r <= was_parked_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write lock and fault flag.

  logic wlock_r, wlock_nxt;
  logic fault_r, fault_nxt;
  logic host_wprot;
  logic fault_event;

  // Stray erase or write current, or a dead transducer lamp, is a fault.
  assign fault_event = ((erase_cur || write_cur) && !wgate) ||
                       !lamp_ok;

  // Host protect and fault events win over clearing so neither is lost in the clearing cycle; recycle beats a press.
  always_comb begin
    wlock_nxt = wlock_r;
    fault_nxt = fault_r;
    if (lock_sw.press) begin
      wlock_nxt = !wlock_r;
      fault_nxt = 1'b0;
    end
    if (recycle) begin
      wlock_nxt = 1'b0;
      fault_nxt = 1'b0;
    end
    if (host_wprot) begin
      wlock_nxt = 1'b1;
    end
    if (fault_event) begin
      fault_nxt = 1'b1;
    end
  end

  // Register the flags.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wlock_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      wlock_r <= wlock_nxt;
      fault_r <= fault_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and lamps.

  logic ready;
  logic [31:0] stat_word;

  // Ready needs speed, loaded heads and safe interlocks while running.
  assign ready = (state_r == ST_RUNNING) && at_speed && hd_loaded &&
                 interlock_safe && run_sw.level;

  // Door stays locked except once fully parked.
  assign door_lock_o   = (state_r != ST_PARKED);
  // Motor power drops outside spin-up, head load and run so the spindle coasts.
  assign motor_power_o = (state_r == ST_SPINUP) ||
                         (state_r == ST_LOADHD) ||
                         (state_r == ST_RUNNING);
  assign head_load_o   = (state_r == ST_LOADHD) ||
                         (state_r == ST_RUNNING);
  // A lost ready also inhibits writing, which limits damage from parking.
  assign write_inhibit_o = wlock_r || !ready;

  assign run_lamp_o    = (state_r == ST_RUNNING);
  assign park_lamp_o   = (state_r == ST_PARKED) && hd_retr &&
                         spin_stop && !run_sw.level;
  assign ready_lamp_o  = ready;
  assign settled_position_lamp_o = ready && !seek_busy && settled;
  assign fault_lamp_o  = fault_r;
  assign write_lock_lamp_o = wlock_r;
  // Activity lamps follow the gates, masked by the lock for writes.
  assign write_activity_lamp_o = wgate && !wlock_r && ready;
  assign read_activity_lamp_o  = rgate && ready;
  assign power_lamp_o  = power_good_i;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave.

  logic [31:0] rdata_r, rdata_nxt;
  logic        ack_r, ack_nxt;
  logic        hit_ctrl, hit_stat;

  assign hit_ctrl = (avs_address_i == `PANEL_CTRL_OFS);
  assign hit_stat = (avs_address_i == `PANEL_STAT_OFS);

  // Writing one to the control bit is the host write-protect command.
  // It lands only at the edge where waitrequest is low.
  assign host_wprot = avs_write_i && ack_r && hit_ctrl &&
                      avs_byteenable_i[0] &&
                      avs_writedata_i[`PANEL_CTRL_WPROT_BIT];

  always_comb begin
    stat_word = 32'h0;
    stat_word[`PANEL_STAT_RUN_BIT]   = run_lamp_o;
    stat_word[`PANEL_STAT_PARK_BIT]  = park_lamp_o;
    stat_word[`PANEL_STAT_READY_BIT] = ready;
    stat_word[`PANEL_STAT_ONTRK_BIT] = settled_position_lamp_o;
    stat_word[`PANEL_STAT_FAULT_BIT] = fault_r;
    stat_word[`PANEL_STAT_WLOCK_BIT] = wlock_r;
    stat_word[`PANEL_STAT_STATE_LSB +: 3] = state_r;
  end

  // Every access answers one cycle after it is seen; unmapped reads zero.
  always_comb begin
    ack_nxt   = (avs_read_i || avs_write_i) && !ack_r;
    rdata_nxt = rdata_r;
    if (avs_read_i && !ack_r) begin
      rdata_nxt = hit_stat ? stat_word :
                  hit_ctrl ? {31'h0, wlock_r} : 32'h0;
    end
  end

  // Register the bus answer.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_r <= 32'h0;
      ack_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ack_r   <= ack_nxt;
    end
  end

  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;

endmodule // disk_panel_interlock_logic

// [design/switch_debounce.sv]
// Three-stage synchroniser and debouncer for one panel switch.
`timescale 1ns/100ps
`include "panel_defines.svh"
module switch_debounce #(
  parameter int unsigned DEBOUNCE_CYC = `PANEL_DEBOUNCE_CYC
) (
  // Clock and reset.
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  // Raw switch pin.
  input  wire logic raw_i,
  // Debounced result.
  switch_if.src     sw
);

  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic       level_r;
  logic       level_nxt;
  logic       press_r;
  logic       press_nxt;

  // Stage one feeds only stage two; stages two and three are compared.
  always_comb begin
    sync_nxt  = {sync_r[1:0], raw_i};
    cnt_nxt   = cnt_r;
    level_nxt = level_r;
    press_nxt = 1'b0;
    if (sync_r[1] != sync_r[2] || sync_r[2] == level_r) begin
      cnt_nxt = 32'h0;
    end else if (cnt_r >= DEBOUNCE_CYC - 1) begin
      cnt_nxt   = 32'h0;
      level_nxt = sync_r[2];
      press_nxt = sync_r[2];
    end else begin
      cnt_nxt = cnt_r + 32'h1;
    end
  end

  // Register the filter state.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sync_r  <= 3'h0;
      cnt_r   <= 32'h0;
      level_r <= 1'b0;
      press_r <= 1'b0;
    end else begin
      sync_r  <= sync_nxt;
      cnt_r   <= cnt_nxt;
      level_r <= level_nxt;
      press_r <= press_nxt;
    end
  end

  assign sw.level = level_r;
  assign sw.press = press_r;

endmodule // switch_debounce

// [shared/panel_defines.svh]
// Timing counts and reset values for the disk panel interlock logic.
`ifndef PANEL_DEFINES_SVH
`define PANEL_DEFINES_SVH

// Clock rate in kHz.
`define PANEL_CLK_KHZ          100000
// Revolution interval that counts as unsafe spindle speed, in ms.
`define PANEL_REV_LIMIT_MS     45
`define PANEL_REV_LIMIT_CYC    (`PANEL_REV_LIMIT_MS * `PANEL_CLK_KHZ)
// Switch debounce time in ms.
`define PANEL_DEBOUNCE_MS      10
`define PANEL_DEBOUNCE_CYC     (`PANEL_DEBOUNCE_MS * `PANEL_CLK_KHZ)
// Spin-up and head-load supervision timeouts in ms.
`define PANEL_SPIN_TMO_MS      10000
`define PANEL_SPIN_TMO_CYC     (`PANEL_SPIN_TMO_MS * `PANEL_CLK_KHZ)
// Sensor synchroniser reset levels; only the transducer lamp idles high.
`define PANEL_SENSE_RST        14'h0040
// Register bus offsets.
`define PANEL_CTRL_OFS         4'h0
`define PANEL_STAT_OFS         4'h4
// Control register bit positions.
`define PANEL_CTRL_WPROT_BIT   0
// Status register bit positions.
`define PANEL_STAT_RUN_BIT     0
`define PANEL_STAT_PARK_BIT    1
`define PANEL_STAT_READY_BIT   2
`define PANEL_STAT_ONTRK_BIT   3
`define PANEL_STAT_FAULT_BIT   4
`define PANEL_STAT_WLOCK_BIT   5
`define PANEL_STAT_STATE_LSB   8

`endif

// [shared/panel_pkg.sv]
// Types shared by the disk panel interlock logic.
package panel_pkg;

  // Drive sequencing states, Gray coded along the spin-up/down path.
  typedef enum logic [2:0] {
    ST_PARKED   = 3'b000,
    ST_SPINUP   = 3'b001,
    ST_LOADHD   = 3'b011,
    ST_RUNNING  = 3'b111,
    ST_UNLOADHD = 3'b110,
    ST_SPINDOWN = 3'b100
  } drive_state_type;

endpackage

// [shared/switch_if.sv]
// Interface carrying a debounced switch level and its press pulse.
`timescale 1ns/100ps
interface switch_if;
  logic level;
  logic press;
  modport src (output level, output press);
  modport dst (input level, input press);
endinterface

// [sim/disk_panel_interlock_logic_asserts.sv]
// Port-level checks on the disk panel interlock logic.
`timescale 1ns/100ps
module panel_asserts #(
  parameter int unsigned REV_LIMIT_CYC = 200,
  parameter int unsigned DEBOUNCE_CYC  = 4,
  parameter int unsigned SPIN_TMO_CYC  = 2000
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Drives and lamps of the block.
  input wire logic door_lock_o,
  input wire logic motor_power_o,
  input wire logic head_load_o,
  input wire logic write_inhibit_o,
  input wire logic run_lamp_o,
  input wire logic park_lamp_o,
  input wire logic ready_lamp_o,
  input wire logic settled_position_lamp_o,
  input wire logic write_lock_lamp_o,
  input wire logic write_activity_lamp_o
);
  // One clock domain, so one default clock and disable.
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // Lamps must agree with the drives they announce.
  run_drive_a: assert property (
    run_lamp_o |-> door_lock_o && motor_power_o && head_load_o)
    else $error("run lamp without door, motor and heads");
  park_coast_a: assert property (
    park_lamp_o |-> !motor_power_o && !head_load_o && !run_lamp_o)
    else $error("park lamp while driven");
  ready_park_a: assert property (
    ready_lamp_o |-> !park_lamp_o)
    else $error("ready and park lamps together");
  track_ready_a: assert property (
    settled_position_lamp_o |-> ready_lamp_o)
    else $error("on-track lamp without ready");
  write_gate_a: assert property (
    write_activity_lamp_o |-> ready_lamp_o && !write_lock_lamp_o)
    else $error("write lamp while locked or not ready");
  inhibit_eq_a: assert property (
    write_inhibit_o == (write_lock_lamp_o || !ready_lamp_o))
    else $error("write inhibit disagrees with lock and ready");
  // After a reset the spindle is unpowered and the door held.
  reset_safe_a: assert property (
    $fell(reset_i) |-> door_lock_o && !motor_power_o && !head_load_o)
    else $error("unsafe drives after reset");
  // Leaving run turns the run lamp off before the park lamp shows.
  run_stop_a: assert property (
    $fell(run_lamp_o) |-> !park_lamp_o ##1 !run_lamp_o)
    else $error("run lamp flicker on stop");
endmodule // panel_asserts

bind disk_panel_interlock_logic panel_asserts #(
  .REV_LIMIT_CYC(REV_LIMIT_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC),
  .SPIN_TMO_CYC(SPIN_TMO_CYC)
) chk_u (
  .ref_clk_i, .reset_i, .door_lock_o, .motor_power_o, .head_load_o,
  .write_inhibit_o, .run_lamp_o, .park_lamp_o, .ready_lamp_o,
  .settled_position_lamp_o, .write_lock_lamp_o, .write_activity_lamp_o
);

// [sim/disk_panel_interlock_logic_tb.sv]
// Self-checking bench for the disk panel interlock logic.
`timescale 1ns/100ps
`include "panel_defines.svh"
module disk_panel_interlock_logic_tb;
  import panel_pkg::*;
  `define CHK(nm, e, v) begin n_tests++; if ((v) !== (e)) begin fails++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, v); end end
  `define WAITC(c) begin k = 0; while (!(c) && k < 500) begin \
    @(posedge ref_clk_i); k++; end end
  localparam int REV = 200;

  logic ref_clk_i = '0, reset_i = '1, idx_en = '1;
  logic run_select_i = '0, write_lock_sw_i = '0, cartridge_seated_i = '0;
  logic door_closed_i = '1, transducer_lamp_ok_i = '1, erase_current_i = '0;
  logic write_current_i = '0, write_gate_i = '0, read_gate_i = '0;
  logic seek_busy_i = '0, heads_settled_i = '0, power_good_i = '1;
  logic speed_ok_i, heads_loaded_i, heads_retracted_i, spindle_stopped_i;
  logic index_pulse_i, door_lock_o, motor_power_o, head_load_o;
  logic write_inhibit_o, run_lamp_o, park_lamp_o, ready_lamp_o;
  logic settled_position_lamp_o, fault_lamp_o, write_lock_lamp_o;
  logic write_activity_lamp_o, read_activity_lamp_o, power_lamp_o;
  logic avs_read_i = '0, avs_write_i = '0, avs_waitrequest_o;
  logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd_d;
  int fails = 0, n_tests = 0, k;

  ////////////////////////////////////////////////////////////////////////
  // Block under test and the drive mechanics it controls.
  disk_panel_interlock_logic #(.REV_LIMIT_CYC(REV), .DEBOUNCE_CYC(4),
    .SPIN_TMO_CYC(2000)) dut_u (
    .ref_clk_i, .reset_i, .run_select_i, .write_lock_sw_i,
    .cartridge_seated_i, .door_closed_i, .speed_ok_i, .heads_loaded_i,
    .heads_retracted_i, .spindle_stopped_i, .index_pulse_i,
    .transducer_lamp_ok_i, .erase_current_i, .write_current_i,
    .write_gate_i, .read_gate_i, .seek_busy_i, .heads_settled_i,
    .power_good_i, .door_lock_o, .motor_power_o, .head_load_o,
    .write_inhibit_o, .run_lamp_o, .park_lamp_o, .ready_lamp_o,
    .settled_position_lamp_o, .fault_lamp_o, .write_lock_lamp_o,
    .write_activity_lamp_o, .read_activity_lamp_o, .power_lamp_o,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o);
  drive_mech_model mech_u (.ref_clk_i, .reset_i,
    .motor_power_i(motor_power_o), .head_load_i(head_load_o),
    .index_en_i(idx_en), .speed_ok_o(speed_ok_i),
    .heads_loaded_o(heads_loaded_i), .heads_retracted_o(heads_retracted_i),
    .spindle_stopped_o(spindle_stopped_i), .index_pulse_o(index_pulse_i));

  // Free-running 100 MHz clock.
  always #5 ref_clk_i = ~ref_clk_i;

  ////////////////////////////////////////////////////////////////////////
  // Access tasks; every change lands just after a rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Holds the request until waitrequest is seen low, so slow answers work.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    if (w) avs_write_i <= 1'b1;
    else avs_read_i <= 1'b1;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    rd_d = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  // A press held well past the debounce time, then a full release.
  task automatic press;
    write_lock_sw_i <= 1'b1;
    cyc(15);
    write_lock_sw_i <= 1'b0;
    cyc(15);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence of tests.
  initial begin
    cyc(6);
    reset_i <= 1'b0;
    `WAITC(park_lamp_o === 1'b1)
    `CHK("park lamp", 1'b1, park_lamp_o)
    `CHK("door lock", 1'b0, door_lock_o)
    `CHK("motor", 1'b0, motor_power_o)
    `CHK("reset fault", 1'b0, fault_lamp_o)
    `CHK("power lamp", 1'b1, power_lamp_o)
    power_good_i <= 1'b0;
    cyc(1);
    `CHK("power off", 1'b0, power_lamp_o)
    power_good_i <= 1'b1;
    $display("test park_after_reset done");
    run_select_i <= 1'b1;
    cyc(60);
    `CHK("no cart motor", 1'b0, motor_power_o)
    `CHK("no cart door", 1'b0, door_lock_o)
    `CHK("park on run", 1'b0, park_lamp_o)
    cartridge_seated_i <= 1'b1;
    `WAITC(motor_power_o === 1'b1)
    `CHK("spin door", 1'b1, door_lock_o)
    `WAITC(ready_lamp_o === 1'b1)
    `CHK("run lamp", 1'b1, run_lamp_o)
    `CHK("heads", 1'b1, head_load_o)
    bus(1'b0, `PANEL_STAT_OFS, 32'h0);
    `CHK("state", ST_RUNNING, rd_d[10:8])
    `CHK("stat ready", 1'b1, rd_d[`PANEL_STAT_READY_BIT])
    $display("test run_start done");
    heads_settled_i <= 1'b1;
    cyc(10);
    `CHK("on track", 1'b1, settled_position_lamp_o)
    seek_busy_i <= 1'b1;
    cyc(10);
    `CHK("seek track", 1'b0, settled_position_lamp_o)
    seek_busy_i <= 1'b0;
    read_gate_i <= 1'b1;
    cyc(10);
    `CHK("read lamp", 1'b1, read_activity_lamp_o)
    read_gate_i <= 1'b0;
    write_gate_i <= 1'b1;
    write_current_i <= 1'b1;
    cyc(10);
    `CHK("read off", 1'b0, read_activity_lamp_o)
    `CHK("write lamp", 1'b1, write_activity_lamp_o)
    write_gate_i <= 1'b0;
    write_current_i <= 1'b0;
    cyc(10);
    `CHK("write off", 1'b0, write_activity_lamp_o)
    `CHK("gated write", 1'b0, fault_lamp_o)
    $display("test lamps done");
    write_gate_i <= 1'b1;
    press();
    `CHK("lock on", 1'b1, write_lock_lamp_o)
    `CHK("write blocked", 1'b0, write_activity_lamp_o)
    write_gate_i <= 1'b0;
    press();
    `CHK("lock off", 1'b0, write_lock_lamp_o)
    bus(1'b1, `PANEL_CTRL_OFS, 32'h1);
    cyc(1);
    `CHK("host lock", 1'b1, write_lock_lamp_o)
    bus(1'b0, `PANEL_CTRL_OFS, 32'h0);
    `CHK("ctrl read", 1'b1, rd_d[`PANEL_CTRL_WPROT_BIT])
    bus(1'b0, 4'h8, 32'h0);
    `CHK("unmapped", 32'h0, rd_d)
    $display("test lock done");
    erase_current_i <= 1'b1;
    cyc(10);
    erase_current_i <= 1'b0;
    cyc(30);
    `CHK("fault held", 1'b1, fault_lamp_o)
    press();
    `CHK("fault clear", 1'b0, fault_lamp_o)
    `CHK("lock toggled", 1'b0, write_lock_lamp_o)
    bus(1'b1, `PANEL_CTRL_OFS, 32'h1);
    transducer_lamp_ok_i <= 1'b0;
    cyc(10);
    `CHK("lamp fault", 1'b1, fault_lamp_o)
    transducer_lamp_ok_i <= 1'b1;
    run_select_i <= 1'b0;
    `WAITC(park_lamp_o === 1'b1)
    `CHK("park motor", 1'b0, motor_power_o)
    `CHK("park ready", 1'b0, ready_lamp_o)
    `CHK("park door", 1'b0, door_lock_o)
    `CHK("park fault", 1'b1, fault_lamp_o)
    run_select_i <= 1'b1;
    `WAITC(ready_lamp_o === 1'b1)
    `CHK("recycle lock", 1'b0, write_lock_lamp_o)
    `CHK("recycle fault", 1'b0, fault_lamp_o)
    $display("test recycle done");
    idx_en <= 1'b0;
    `WAITC(run_lamp_o === 1'b0)
    `CHK("index drop", 1'b0, run_lamp_o)
    `CHK("index span", 1'b1, k >= REV - 60 && k <= REV + 20)
    $display("test index_loss done");
    tally_and_finish();
  end

  // A hang ends the run through the same closing task.
  initial begin
    cyc(20000);
    fails++;
    tally_and_finish();
  end
endmodule // disk_panel_interlock_logic_tb

// [sim/drive_mech_model.sv]
// Behavioural spindle, head carriage and index sensor of the drive.
`timescale 1ns/100ps
module drive_mech_model (
  // Clock and reset.
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  // Drives from the panel logic and bench control.
  input  wire logic motor_power_i,
  input  wire logic head_load_i,
  input  wire logic index_en_i,
  // Sensor levels.
  output logic      speed_ok_o,
  output logic      heads_loaded_o,
  output logic      heads_retracted_o,
  output logic      spindle_stopped_o,
  output logic      index_pulse_o
);
  logic [5:0] spd_r;
  logic [3:0] hd_r;
  logic [5:0] idx_r;

  // Speed ramps up under power and coasts down without it.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      spd_r <= 6'h0;
      hd_r  <= 4'h0;
      idx_r <= 6'h0;
    end else begin
      if (motor_power_i && spd_r != 6'h20) spd_r <= spd_r + 6'h1;
      else if (!motor_power_i && spd_r != 6'h0) spd_r <= spd_r - 6'h1;
      if (head_load_i && hd_r != 4'h8) hd_r <= hd_r + 4'h1;
      else if (!head_load_i && hd_r != 4'h0) hd_r <= hd_r - 4'h1;
      idx_r <= (idx_r == 6'h31) ? 6'h0 : idx_r + 6'h1;
    end
  end

  // Sensors never claim a state the mechanics have not reached.
  assign speed_ok_o        = spd_r == 6'h20;
  assign spindle_stopped_o = spd_r == 6'h0;
  assign heads_loaded_o    = hd_r == 4'h8;
  assign heads_retracted_o = hd_r == 4'h0;
  // One short pulse per revolution while turning, period 50 cycles.
  assign index_pulse_o = index_en_i && spd_r != 6'h0 && idx_r < 6'h3;
endmodule // drive_mech_model
